// ==== rtl/cil_can_int.v ====
// Local design decisions: the register addresses and register access over AXI4-Lite.
`include "cil_defs.vh"
`default_nettype none

module cil_can_int (
   input wire aclk,
   input wire aresetn,
   input wire [7:0] s_axi_awaddr,
   input wire [2:0] s_axi_awprot,
   input wire s_axi_awvalid,
   output reg s_axi_awready,
   input wire [31:0] s_axi_wdata,
   input wire [3:0] s_axi_wstrb,
   input wire s_axi_wvalid,
   output reg s_axi_wready,
   output reg [1:0] s_axi_bresp,
   output reg s_axi_bvalid,
   input wire s_axi_bready,
   input wire [7:0] s_axi_araddr,
   input wire [2:0] s_axi_arprot,
   input wire s_axi_arvalid,
   output reg s_axi_arready,
   output reg [31:0] s_axi_rdata,
   output reg [1:0] s_axi_rresp,
   output reg s_axi_rvalid,
   input wire s_axi_rready,
   input wire [1:0] rx_done,
   input wire [2:0] tx_empty,
   input wire msg_error,
   input wire bus_activity,
   input wire assembly_accept,
   input wire assembly_buf_sel,
   input wire [1:0] rx_buf_busy,
   input wire [7:0] rx_err_cnt,
   input wire [8:0] tx_err_cnt,
   output reg [2:0] pending_source_code,
   output reg irq,
   output reg sleep_mode,
   output reg error_passive,
   output reg bus_off
);

   // ----------------------------------------------------------------
   // bus slave state
   // ----------------------------------------------------------------
   reg aw_got_reg;
   reg w_got_reg;
   reg [7:0] aw_addr_reg;
   reg [7:0] w_data_reg;
   reg w_lane0_reg;
   wire aw_take;
   wire w_take;
   wire ar_take;
   wire do_write;
   wire wr_map;
   wire wr_flag;
   wire wr_enable;
   wire wr_comm;
   wire wr_module;

   // ----------------------------------------------------------------
   // block state
   // ----------------------------------------------------------------
   reg [7:0] flag_reg;
   reg [7:0] flag_next;
   reg [7:0] enable_reg;
   reg [1:0] ovf_reg;
   reg [1:0] ovf_next;
   reg [4:0] state_reg;
   reg [4:0] state_next;
   reg [2:0] code_next;
   reg [31:0] rd_word;
   reg rd_hit;
   wire [7:0] flag_set;
   wire [7:0] flag_hold;
   wire [7:0] gated;
   wire [1:0] ovf_set;
   wire wake_evt;
   wire err_evt;
   wire [7:0] comm_view;

   assign aw_take = s_axi_awvalid & s_axi_awready;
   assign w_take = s_axi_wvalid & s_axi_wready;
   assign ar_take = s_axi_arvalid & s_axi_arready;
   assign do_write = aw_got_reg & w_got_reg & ~s_axi_bvalid;
   assign wr_map = do_write & w_lane0_reg;
   assign wr_flag = wr_map & (aw_addr_reg == `CIL_ADDR_FLAG);
   assign wr_enable = wr_map & (aw_addr_reg == `CIL_ADDR_ENABLE);
   assign wr_comm = wr_map & (aw_addr_reg == `CIL_ADDR_COMM);
   assign wr_module = wr_map & (aw_addr_reg == `CIL_ADDR_MODULE);

   // ----------------------------------------------------------------
   // write channel
   // ----------------------------------------------------------------
   // ready is offered one cycle after valid so it comes from a flop
   always @(posedge aclk)
   begin
      if (!aresetn)
      begin
         s_axi_awready <= 1'b0;
         s_axi_wready <= 1'b0;
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= `CIL_RESP_OKAY;
         aw_got_reg <= 1'b0;
         w_got_reg <= 1'b0;
         aw_addr_reg <= 8'h00;
         w_data_reg <= 8'h00;
         w_lane0_reg <= 1'b0;
      end
      else
      begin
         s_axi_awready <= s_axi_awvalid & ~s_axi_awready & ~aw_got_reg & ~s_axi_bvalid;
         s_axi_wready <= s_axi_wvalid & ~s_axi_wready & ~w_got_reg & ~s_axi_bvalid;
         if (aw_take)
         begin
            aw_got_reg <= 1'b1;
            // low address bits dropped, so byte offsets alias their word
            aw_addr_reg <= {s_axi_awaddr[7:2], 2'b00};
         end
         if (w_take)
         begin
            w_got_reg <= 1'b1;
            w_data_reg <= s_axi_wdata[7:0];
            w_lane0_reg <= s_axi_wstrb[0];
         end
         if (do_write)
         begin
            aw_got_reg <= 1'b0;
            w_got_reg <= 1'b0;
            s_axi_bvalid <= 1'b1;
            // the counter word is read-only yet answers okay to a write
            if (aw_addr_reg <= `CIL_ADDR_ERRCNT)
               s_axi_bresp <= `CIL_RESP_OKAY;
            else
               s_axi_bresp <= `CIL_RESP_DECERR;
         end
         else if (s_axi_bvalid & s_axi_bready)
            s_axi_bvalid <= 1'b0;
      end
   end

   // ----------------------------------------------------------------
   // read channel
   // ----------------------------------------------------------------
   assign comm_view = {state_reg[`CIL_C_RXWARN - 2] | state_reg[`CIL_C_TXWARN - 2],
                       state_reg, ovf_reg};

   always @*
   begin
      // live address is safe: the master holds it until arready
      rd_word = 32'h0000_0000;
      rd_hit = 1'b1;
      if ({s_axi_araddr[7:2], 2'b00} == `CIL_ADDR_FLAG)
         rd_word = {24'h00_0000, flag_reg};
      else if ({s_axi_araddr[7:2], 2'b00} == `CIL_ADDR_ENABLE)
         rd_word = {24'h00_0000, enable_reg};
      else if ({s_axi_araddr[7:2], 2'b00} == `CIL_ADDR_COMM)
         rd_word = {24'h00_0000, comm_view};
      else if ({s_axi_araddr[7:2], 2'b00} == `CIL_ADDR_MODULE)
         rd_word = {28'h000_0000, pending_source_code, sleep_mode};
      else if ({s_axi_araddr[7:2], 2'b00} == `CIL_ADDR_ERRCNT)
         rd_word = {7'h00, tx_err_cnt, 8'h00, rx_err_cnt};
      else
         rd_hit = 1'b0;
   end

   always @(posedge aclk)
   begin
      if (!aresetn)
      begin
         s_axi_arready <= 1'b0;
         s_axi_rvalid <= 1'b0;
         s_axi_rdata <= 32'h0000_0000;
         s_axi_rresp <= `CIL_RESP_OKAY;
      end
      else
      begin
         s_axi_arready <= s_axi_arvalid & ~s_axi_arready & ~s_axi_rvalid;
         if (ar_take)
         begin
            s_axi_rvalid <= 1'b1;
            // captured at the take, so it cannot move while rvalid stands
            s_axi_rdata <= rd_word;
            s_axi_rresp <= rd_hit ? `CIL_RESP_OKAY : `CIL_RESP_DECERR;
         end
         else if (s_axi_rvalid & s_axi_rready)
            s_axi_rvalid <= 1'b0;
      end
   end

   // ----------------------------------------------------------------
   // error state from the counters
   // ----------------------------------------------------------------
   always @*
   begin
      state_next[`CIL_C_RXWARN - 2] = {1'b0, rx_err_cnt} >= `CIL_WARN_LIMIT;
      state_next[`CIL_C_TXWARN - 2] = tx_err_cnt >= `CIL_WARN_LIMIT;
      state_next[`CIL_C_RXPASS - 2] = {1'b0, rx_err_cnt} > `CIL_PASSIVE_LIMIT;
      state_next[`CIL_C_TXPASS - 2] = tx_err_cnt > `CIL_PASSIVE_LIMIT;
      // nine bits let the count pass 255 without wrapping
      state_next[`CIL_C_BUSOFF - 2] = tx_err_cnt > `CIL_BUSOFF_LIMIT;
   end

   // ----------------------------------------------------------------
   // receive overflow
   // ----------------------------------------------------------------
   // a busy target loses the message; this bit and the error flag record it
   assign ovf_set[0] = assembly_accept & ~assembly_buf_sel & rx_buf_busy[0];
   assign ovf_set[1] = assembly_accept & assembly_buf_sel & rx_buf_busy[1];

   always @*
   begin
      ovf_next = ovf_reg;
      // only a host write of zero clears it; the set wins in a tie
      if (wr_comm)
         ovf_next = ovf_reg & w_data_reg[1:0];
      ovf_next = ovf_next | ovf_set;
   end

   // ----------------------------------------------------------------
   // interrupt flags
   // ----------------------------------------------------------------
   // any step of the counter state counts, up or down
   assign err_evt = (|ovf_set) | (state_next != state_reg);
   assign wake_evt = sleep_mode & enable_reg[`CIL_B_WAKE] & bus_activity;

   assign flag_set[`CIL_B_RX0] = rx_done[0];
   assign flag_set[`CIL_B_RX1] = rx_done[1];
   assign flag_set[`CIL_B_TX2:`CIL_B_TX0] = tx_empty;
   assign flag_set[`CIL_B_ERR] = err_evt;
   assign flag_set[`CIL_B_WAKE] = wake_evt;
   assign flag_set[`CIL_B_MSGERR] = msg_error;

   // causes that are still present block a clear
   // pulse causes are gone a cycle later, so nothing holds their clear
   assign flag_hold[`CIL_B_TX2:`CIL_B_RX0] = 5'h00;
   assign flag_hold[`CIL_B_ERR] = |ovf_reg;
   assign flag_hold[`CIL_B_WAKE] = bus_activity & sleep_mode;
   assign flag_hold[`CIL_B_MSGERR] = 1'b0;

   genvar gi;
   generate
      for (gi = 0; gi < 8; gi = gi + 1)
      begin : g_flag
         always @*
         begin
            flag_next[gi] = flag_reg[gi];
            if (wr_flag & ~w_data_reg[gi] & ~flag_hold[gi])
               flag_next[gi] = 1'b0;
            if (flag_set[gi])
               flag_next[gi] = 1'b1;
         end
      end
   endgenerate

   // ----------------------------------------------------------------
   // pending source priority
   // ----------------------------------------------------------------
   // flags record every event but wake; enables gate the code, irq and the wake flag
   assign gated = flag_reg & enable_reg;

   always @*
   begin
      // re-evaluated every cycle, so a cleared source yields to the next
      if (gated[`CIL_B_ERR])
         code_next = `CIL_CODE_ERR;
      else if (gated[`CIL_B_TX0])
         code_next = `CIL_CODE_TX0;
      else if (gated[`CIL_B_TX1])
         code_next = `CIL_CODE_TX1;
      else if (gated[`CIL_B_TX2])
         code_next = `CIL_CODE_TX2;
      else if (gated[`CIL_B_RX0])
         code_next = `CIL_CODE_RX0;
      else if (gated[`CIL_B_RX1])
         code_next = `CIL_CODE_RX1;
      else if (gated[`CIL_B_WAKE])
         code_next = `CIL_CODE_WAKE;
      else
         code_next = `CIL_CODE_NONE;
   end

   // ----------------------------------------------------------------
   // state registers
   // ----------------------------------------------------------------
   always @(posedge aclk)
   begin
      if (!aresetn)
      begin
         flag_reg <= `CIL_RST_FLAG;
         enable_reg <= `CIL_RST_ENABLE;
         ovf_reg <= 2'h0;
         state_reg <= 5'h00;
         sleep_mode <= 1'b0;
         pending_source_code <= `CIL_CODE_NONE;
         irq <= 1'b0;
         error_passive <= 1'b0;
         bus_off <= 1'b0;
      end
      else
      begin
         flag_reg <= flag_next;
         ovf_reg <= ovf_next;
         state_reg <= state_next;
         if (wr_enable)
            enable_reg <= w_data_reg;
         // wake-up overrides a sleep request in the same cycle
         if (wake_evt)
            sleep_mode <= 1'b0;
         else if (wr_module)
            sleep_mode <= w_data_reg[0];
         pending_source_code <= code_next;
         // message error is outside the code but still interrupts
         irq <= |gated;
         // pins lag the counters two cycles: counter to state, state to pin
         error_passive <= state_reg[`CIL_C_RXPASS - 2] | state_reg[`CIL_C_TXPASS - 2];
         bus_off <= state_reg[`CIL_C_BUSOFF - 2];
      end
   end

endmodule

`default_nettype wire

// ==== rtl/cil_defs.vh ====
`ifndef CIL_DEFS_VH
`define CIL_DEFS_VH

// ----------------------------------------------------------------
// register byte addresses
// ----------------------------------------------------------------
`define CIL_ADDR_FLAG 8'h00
`define CIL_ADDR_ENABLE 8'h04
`define CIL_ADDR_COMM 8'h08
`define CIL_ADDR_MODULE 8'h0c
`define CIL_ADDR_ERRCNT 8'h10

// ----------------------------------------------------------------
// flag and enable bit positions (same layout in both registers)
// ----------------------------------------------------------------
`define CIL_B_RX0 0
`define CIL_B_RX1 1
`define CIL_B_TX0 2
`define CIL_B_TX1 3
`define CIL_B_TX2 4
`define CIL_B_ERR 5
`define CIL_B_WAKE 6
`define CIL_B_MSGERR 7

// ----------------------------------------------------------------
// communication status bit positions
// ----------------------------------------------------------------
`define CIL_C_OVF0 0
`define CIL_C_OVF1 1
`define CIL_C_RXWARN 2
`define CIL_C_TXWARN 3
`define CIL_C_RXPASS 4
`define CIL_C_TXPASS 5
`define CIL_C_BUSOFF 6
`define CIL_C_WARN 7

// ----------------------------------------------------------------
// reset values and limits
// ----------------------------------------------------------------
`define CIL_RST_FLAG 8'h00
`define CIL_RST_ENABLE 8'h00
`define CIL_RST_COMM 8'h00
`define CIL_WARN_LIMIT 9'h060
`define CIL_PASSIVE_LIMIT 9'h07f
`define CIL_BUSOFF_LIMIT 9'h0ff

// ----------------------------------------------------------------
// pending source codes
// ----------------------------------------------------------------
`define CIL_CODE_NONE 3'h0
`define CIL_CODE_ERR 3'h1
`define CIL_CODE_TX2 3'h2
`define CIL_CODE_TX1 3'h3
`define CIL_CODE_TX0 3'h4
`define CIL_CODE_RX1 3'h5
`define CIL_CODE_RX0 3'h6
`define CIL_CODE_WAKE 3'h7

// ----------------------------------------------------------------
// bus responses
// ----------------------------------------------------------------
`define CIL_RESP_OKAY 2'h0
`define CIL_RESP_DECERR 2'h3

`endif

// ==== sim/cil_can_int_props.sv ====
`default_nettype none
module cil_can_int_props (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic [7:0] s_axi_araddr,
   input wire logic [31:0] s_axi_rdata,
   input wire logic [1:0] s_axi_rresp,
   input wire logic s_axi_rvalid,
   input wire logic s_axi_rready,
   input wire logic [1:0] s_axi_bresp,
   input wire logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic bus_activity,
   input wire logic [7:0] rx_err_cnt,
   input wire logic [8:0] tx_err_cnt,
   input wire logic [2:0] pending_source_code,
   input wire logic irq,
   input wire logic sleep_mode,
   input wire logic error_passive,
   input wire logic bus_off
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking @(posedge aclk); endclocking
   default disable iff (!aresetn);
   // --------
   // properties
   // --------
   property p_b_hold;
      s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp);
   endproperty
   a_b_hold: assert property (p_b_hold) else $error("bresp moved");
   property p_r_hold;
      s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable({s_axi_rresp, s_axi_rdata});
   endproperty
   a_r_hold: assert property (p_r_hold) else $error("read answer moved");
   property p_r_resp;
      $rose(s_axi_rvalid) |-> s_axi_rresp == (($past(s_axi_araddr[7:2]) > 6'h04) ? 2'h3 : 2'h0);
   endproperty
   a_r_resp: assert property (p_r_resp) else $error("rresp wrong");
   property p_r_zero;
      s_axi_rvalid && s_axi_rresp == 2'h3 |-> s_axi_rdata == 32'h0;
   endproperty
   a_r_zero: assert property (p_r_zero) else $error("unmapped data");
   property p_quiet;
      !irq |-> pending_source_code == 3'h0;
   endproperty
   a_quiet: assert property (p_quiet) else $error("code without irq");
   property p_busoff;
      $past(aresetn) && $past(aresetn, 2) |-> bus_off == ($past(tx_err_cnt, 2) > 9'h0ff);
   endproperty
   a_busoff: assert property (p_busoff) else $error("bus_off wrong");
   property p_passive;
      $past(aresetn) && $past(aresetn, 2) |-> error_passive ==
         ($past(rx_err_cnt, 2) > 8'h7f || $past(tx_err_cnt, 2) > 9'h07f);
   endproperty
   a_passive: assert property (p_passive) else $error("passive wrong");
   property p_wake;
      $past(aresetn) && $fell(sleep_mode) && $past(bus_activity) |-> ##[0:1] irq;
   endproperty
   a_wake: assert property (p_wake) else $error("wake without irq");
   c_wake: cover property ($fell(sleep_mode));
   c_busoff: cover property ($rose(bus_off));
   c_dec: cover property (s_axi_rvalid && s_axi_rresp == 2'h3);
endmodule
bind cil_can_int cil_can_int_props u_props (.aclk, .aresetn, .s_axi_araddr, .s_axi_rdata,
   .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
   .bus_activity, .rx_err_cnt, .tx_err_cnt, .pending_source_code, .irq, .sleep_mode,
   .error_passive, .bus_off);
`default_nettype wire

// ==== sim/cil_can_int_tb_top.sv ====
`default_nettype none
module cil_can_int_tb_top;
   timeunit 1ns;
   timeprecision 1ps;
   logic aclk, aresetn, awvalid, wvalid, bready, arvalid, rready;
   logic [7:0] awaddr, araddr;
   logic [31:0] wdata;
   logic [3:0] wstrb;
   wire awready, wready, bvalid, arready, rvalid, irq, e_pass, b_off, me, ba, acc, sel, slp;
   wire [1:0] bresp, rresp, rxd, busy;
   wire [2:0] txe, code;
   wire [31:0] rdata;
   wire [7:0] rxc;
   wire [8:0] txc;
   int n_errors = 0;
   int checks_done = 0;
   logic [33:0] exp_q[$];
   logic [31:0] seed = 32'h1d5a3664;
   int clr_bit[7] = '{5, 2, 3, 4, 0, 1, 6};
   logic [2:0] nxt[7] = '{3'h4, 3'h3, 3'h2, 3'h6, 3'h5, 3'h7, 3'h0};
   logic [7:0] rxv[6] = '{8'h5f, 8'h60, 8'h7f, 8'h80, 8'h00, 8'h00};
   logic [8:0] txv[6] = '{9'h000, 9'h000, 9'h05f, 9'h060, 9'h0ff, 9'h100};
   logic [7:0] comm[6] = '{8'h00, 8'h84, 8'h84, 8'h9c, 8'ha8, 8'he8};
   cil_can_int dut (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
      .s_axi_awprot(3'h0), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
      .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
      .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
      .s_axi_araddr(araddr), .s_axi_arprot(3'h0), .s_axi_arvalid(arvalid),
      .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
      .s_axi_rvalid(rvalid), .s_axi_rready(rready), .rx_done(rxd), .tx_empty(txe),
      .msg_error(me), .bus_activity(ba), .assembly_accept(acc), .assembly_buf_sel(sel),
      .rx_buf_busy(busy), .rx_err_cnt(rxc), .tx_err_cnt(txc), .pending_source_code(code),
      .irq(irq), .sleep_mode(slp), .error_passive(e_pass), .bus_off(b_off));
   cil_engine_model eng (.aclk(aclk), .rx_done(rxd), .tx_empty(txe), .msg_error(me),
      .bus_activity(ba), .assembly_accept(acc), .assembly_buf_sel(sel), .rx_buf_busy(busy),
      .rx_err_cnt(rxc), .tx_err_cnt(txc));
   initial
   begin
      aclk = 1'b0;
      forever #5 aclk = ~aclk;
   end
   // --------
   // helpers
   // --------
   function automatic logic [31:0] xs();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction
   task automatic chk(input logic [33:0] got, input logic [33:0] exp);
      checks_done++;
      if (got !== exp)
      begin
         n_errors++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic print_verdict();
      $display("checks %0d errors %0d", checks_done, n_errors);
      if (n_errors == 0 && checks_done > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask
   task automatic wr(input logic [7:0] a, input logic [7:0] d, input logic s = 1'b1);
      logic [31:0] r;
      r = xs();
      exp_q.push_back({((a > 8'h10) ? 2'h3 : 2'h0), 32'h0});
      awaddr <= a;
      wdata <= {r[31:8], d};
      wstrb <= {r[3:1], s};
      {awvalid, wvalid, bready} <= 3'h7;
      do
      begin
         @(posedge aclk);
         if (awready)
            awvalid <= 1'b0;
         if (wready)
            wvalid <= 1'b0;
      end while (bvalid !== 1'b1);
      bready <= 1'b0;
      // one edge with bready low before the next write may raise it
      @(posedge aclk);
   endtask
   task automatic rd(input logic [7:0] a, input logic [31:0] e);
      exp_q.push_back({((a > 8'h10) ? 2'h3 : 2'h0), e});
      araddr <= a;
      {arvalid, rready} <= 2'h3;
      do
      begin
         @(posedge aclk);
         if (arready)
            arvalid <= 1'b0;
      end while (rvalid !== 1'b1);
      rready <= 1'b0;
      @(posedge aclk);
   endtask
   always @(posedge aclk)
   begin
      if (bvalid === 1'b1 && bready)
         chk({bresp, 32'h0}, exp_q.pop_front());
      if (rvalid === 1'b1 && rready)
         chk({rresp, rdata}, exp_q.pop_front());
   end
   // whole run needs about 3 us
   initial
   begin
      #50us;
      n_errors++;
      print_verdict();
   end
   // --------
   // scenarios
   // --------
   initial
   begin
      {aresetn, awvalid, wvalid, bready, arvalid, rready} = 6'h00;
      {awaddr, araddr, wdata, wstrb} = 52'h0;
      repeat (10) @(posedge aclk);
      aresetn <= 1'b1;
      @(posedge aclk);
      for (int i = 0; i < 6; i++)
         rd(8'(i * 4), 32'h0);
      wr(8'h40, 8'hff);
      wr(8'h04, 8'h02);
      eng.ev(7'h21);
      rd(8'h00, 32'h01);
      rd(8'h0c, 32'h00);
      wr(8'h04, 8'h83);
      rd(8'h0c, 32'h0c);
      chk(irq, 1'b1);
      wr(8'h00, 8'hfe);
      eng.ev(7'h02);
      rd(8'h0c, 32'h00);
      chk(irq, 1'b1);
      wr(8'h00, 8'h7f, 1'b0);
      rd(8'h00, 32'h80);
      wr(8'h00, 8'h7f);
      wr(8'h04, 8'h7f);
      wr(8'h0c, 8'h01);
      chk(slp, 1'b1);
      eng.accept(1'b0, 2'h1);
      eng.accept(1'b1, 2'h1);
      eng.ev(7'h7d);
      rd(8'h00, 32'h7f);
      chk(slp, 1'b0);
      rd(8'h08, 32'h01);
      wr(8'h00, 8'hdf);
      rd(8'h0c, 32'h02);
      wr(8'h08, 8'hfe);
      for (int i = 0; i < 7; i++)
      begin
         wr(8'h00, ~(8'h01 << clr_bit[i]));
         rd(8'h0c, {28'h0, nxt[i], 1'b0});
         chk(code, nxt[i]);
      end
      chk(irq, 1'b0);
      // second receive buffer overflows while busy
      eng.accept(1'b1, 2'h2);
      rd(8'h08, 32'h02);
      rd(8'h00, 32'h20);
      wr(8'h08, 8'hfd);
      rd(8'h08, 32'h0);
      for (int i = 0; i < 6; i++)
      begin
         eng.counts(rxv[i], txv[i]);
         rd(8'h08, {24'h0, comm[i]});
         chk(e_pass, rxv[i] > 8'h7f || txv[i] > 9'h07f);
         chk(b_off, txv[i] > 9'h0ff);
      end
      rd(8'h10, 32'h01000000);
      rd(8'h00, 32'h20);
      // mid-run reset; counters go quiet first so no state change follows it
      eng.counts(8'h00, 9'h000);
      aresetn <= 1'b0;
      repeat (2) @(posedge aclk);
      aresetn <= 1'b1;
      @(posedge aclk);
      rd(8'h00, 32'h0);
      rd(8'h04, 32'h0);
      rd(8'h08, 32'h0);
      chk({irq, code, slp}, 5'h00);
      print_verdict();
   end
endmodule
`default_nettype wire

// ==== sim/cil_engine_model.sv ====
`default_nettype none
module cil_engine_model (
   input wire logic aclk,
   output logic [1:0] rx_done,
   output logic [2:0] tx_empty,
   output logic msg_error,
   output logic bus_activity,
   output logic assembly_accept,
   output logic assembly_buf_sel,
   output logic [1:0] rx_buf_busy,
   output logic [7:0] rx_err_cnt,
   output logic [8:0] tx_err_cnt
);
   timeunit 1ns;
   timeprecision 1ps;
   initial
   begin
      {rx_done, tx_empty, msg_error, bus_activity} = 7'h00;
      {assembly_accept, assembly_buf_sel, rx_buf_busy} = 4'h0;
      {rx_err_cnt, tx_err_cnt} = 17'h00000;
   end
   // --------
   // engine strobes, one cycle each; counts holds its values until the next call
   // --------
   task automatic ev(input logic [6:0] v);
      @(posedge aclk);
      {rx_done, tx_empty, msg_error, bus_activity} <= v;
      @(posedge aclk);
      {rx_done, tx_empty, msg_error, bus_activity} <= 7'h00;
   endtask
   // released select flips, so a stale value cannot pass for a live one
   task automatic accept(input logic s, input logic [1:0] busy);
      @(posedge aclk);
      {assembly_accept, assembly_buf_sel, rx_buf_busy} <= {1'b1, s, busy};
      @(posedge aclk);
      {assembly_accept, assembly_buf_sel, rx_buf_busy} <= {1'b0, ~s, 2'h0};
   endtask
   task automatic counts(input logic [7:0] r, input logic [8:0] t);
      @(posedge aclk);
      {rx_err_cnt, tx_err_cnt} <= {r, t};
   endtask
endmodule
`default_nettype wire
